/* File: common/sdram_refresh_pkg.sv */
// Constants, carriers and states for the DRAM/SDRAM refresh sequencer.
// Assumes one system clock domain and one memory (link) clock domain.
package sdram_refresh_pkg;

    localparam int BANKS        = 4;
    localparam int ADDR_W       = 15;
    localparam int DRI_W        = 12;
    localparam int TIME_W       = 4;
    localparam int BEAT_W       = 3;
    localparam int REF_SHIFT    = 5;
    localparam int CNT_W        = DRI_W + REF_SHIFT;
    localparam int AP_BIT       = 10;
    localparam int MRS_CL_LSB   = 4;

    // Byte masks lead the chip selects by two memory clocks
    localparam logic [TIME_W-1:0] MASK_LEAD_CYCLES = 4'h2;
    localparam logic [CNT_W-1:0]  REF_CNT_RESET    = 17'h0_0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO        = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_AP          = 15'h0400;
    localparam logic [3:0]        LINES_HIGH       = 4'hf;
    localparam logic [3:0]        LINES_LOW        = 4'h0;
    localparam logic [1:0]        CKE_HIGH         = 2'h3;
    localparam logic [1:0]        CKE_LOW          = 2'h0;
    localparam logic [2:0]        MCLK_RESET       = 3'h6;

    typedef enum logic [3:0] {
        SELF_REF, IDLE, LOW_POWER, PWR_DOWN, PWR_EXIT, MRS, ACT, RW,
        REF_PALL, REF_MASK, REF_CBR, REF_HOLD, RECOVER, SLEEP_MASK,
        SLEEP_ENTER
    } memFsm_type;

    typedef struct packed {
        logic [3:0]        csLines_n;
        logic [3:0]        maskLines_n;
        logic              rowStrobe_n;
        logic              colStrobe_n;
        logic              writeEnable_n;
        logic [1:0]        clockEnable;
        logic [ADDR_W-1:0] addr;
    } pins_type;

    localparam pins_type PINS_SELF_REFRESH = '{
        csLines_n: 4'h0, maskLines_n: 4'h0, rowStrobe_n: 1'b1,
        colStrobe_n: 1'b1, writeEnable_n: 1'b1, clockEnable: 2'h0,
        addr: 15'h0000};

    typedef struct packed {
        logic              write;
        logic [1:0]        bank;
        logic [BEAT_W-1:0] beatsMinus1;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
    } access_type;

    typedef struct packed {
        logic [BANKS-1:0]  dramBankEnables;
        logic [DRI_W-1:0]  refreshIntervalField;
        logic [TIME_W-1:0] refreshActiveTime;
        logic [TIME_W-1:0] rowPrechargeTime;
        logic [1:0]        casLatencyField;
        logic              clockEnablePinHold;
        logic              memClock1Run;
        logic              memClock2Run;
        logic              ckeAutoPowerdownEn;
        logic              clkAutoPowerdownEn;
        logic              setSelfRefresh;
        logic              enterSleep;
    } ctrl_type;

endpackage

/* File: core/sdram_dram_refresh_sequencer.sv */
// DRAM/SDRAM command sequencer with CBR refresh and sleep self-refresh.
// Assumes control bits are quasi-static and a request is held by the
// system side until its done pulse; the memory clock is the link clock.

// Function
// - Reset enters self-refresh, waits for software
// - Command states other than RW last exactly one cycle
// - No condition true means state holds
// - Cleared pin-hold or run bits force low power
// - Idle exits follow fixed priority order
// - Auto power-down only without higher requests
// - Power-down exits on sleep, refresh, enable, access
// - Access issues activate then one command per beat
// - Last beat uses auto-precharge, others plain
// - Refresh counter counts per memory cycle when enabled
// - Count equals interval times 32 flags refresh
// - Masks low, chip selects low two clocks later
// - Lines high after active time, then precharge holdoff
// - Only hardware reset clears refresh counter, not sleep
// - Only first refresh cycle has strobes low
// - First refresh after reset precharges all banks
// - Single access to disabled bank refreshes once
// - Refresh continues regardless of core idle
// - Sleep holds masks then selects low
// - Self-refresh drives clock enables low throughout
// - Sleep stops clocks with defined levels
// - Access during self-refresh keeps self-refresh
// - Newly enabled bank gets mode register set
module sdram_dram_refresh_sequencer (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         memClk,
    input  wire sdram_refresh_pkg::ctrl_type  ctrl,
    input  wire logic                         reqValid,
    input  wire sdram_refresh_pkg::access_type reqAccess,
    output logic                              reqReady,
    output logic                              reqDone,
    output logic                              selfRefreshActive,
    output sdram_refresh_pkg::pins_type       memPins,
    output logic [2:0]                        syncMemoryClockOut
);
    import sdram_refresh_pkg::*;

    typedef struct packed {
        logic       reqReady;
        logic       reqDone;
        logic       reqTog;
        logic       ackMeta;
        logic       ackSync;
        logic       ackSeen;
        logic       srMeta;
        logic       srSync;
        access_type hold;
    } sysState_type;

    typedef struct packed {
        logic              rstMeta;
        logic              rstSync;
        ctrl_type          ctrlMeta;
        ctrl_type          ctrlSync;
        logic              reqMeta;
        logic              reqSync;
        logic              reqSeen;
        logic              ackTog;
        logic              accessPending;
        memFsm_type        fsm;
        pins_type          pins;
        logic [2:0]        mclk;
        logic [CNT_W-1:0]  refCnt;
        logic              refreshDue;
        logic              firstRefresh;
        logic [BANKS-1:0]  prevEnables;
        logic              mrsPending;
        logic [TIME_W-1:0] timer;
        logic [BEAT_W-1:0] beat;
        logic              disabledRefresh;
        logic              selfRefresh;
    } memState_type;

    localparam sysState_type SYS_RESET = '0;

    sysState_type s_q;
    sysState_type s_d;
    memState_type m_q;
    memState_type m_d;

    function automatic logic [3:0] csFor(input logic [1:0] bank);
        csFor = ~(4'h1 << bank);
    endfunction

    function automatic pins_type pinsFor(input memFsm_type st,
                                         input access_type acc,
                                         input logic [BEAT_W-1:0] beat,
                                         input ctrl_type c,
                                         input logic allBanks);
        pins_type p;
        logic [3:0] refCs;
        p = '{csLines_n: LINES_HIGH, maskLines_n: LINES_HIGH,
              rowStrobe_n: 1'b1, colStrobe_n: 1'b1, writeEnable_n: 1'b1,
              clockEnable: CKE_HIGH, addr: ADDR_ZERO};
        refCs = allBanks ? LINES_LOW : ~c.dramBankEnables;
        unique case (st)
            SELF_REF: begin
                p = PINS_SELF_REFRESH;
            end
            SLEEP_ENTER: begin
                p = PINS_SELF_REFRESH;
                p.rowStrobe_n = 1'b0;
                p.colStrobe_n = 1'b0;
            end
            LOW_POWER: begin
                p.clockEnable = c.clockEnablePinHold ? CKE_HIGH : CKE_LOW;
            end
            PWR_DOWN: begin
                p.clockEnable = c.ckeAutoPowerdownEn ? CKE_LOW : CKE_HIGH;
            end
            MRS: begin
                p.csLines_n = ~c.dramBankEnables;
                p.rowStrobe_n = 1'b0;
                p.colStrobe_n = 1'b0;
                p.writeEnable_n = 1'b0;
                p.addr[MRS_CL_LSB+:2] = c.casLatencyField;
            end
            ACT: begin
                p.csLines_n = csFor(acc.bank);
                p.rowStrobe_n = 1'b0;
                p.addr = acc.row;
            end
            RW: begin
                p.csLines_n = csFor(acc.bank);
                p.colStrobe_n = 1'b0;
                p.writeEnable_n = ~acc.write;
                p.maskLines_n = acc.write ? LINES_LOW : LINES_HIGH;
                p.addr = acc.col;
                p.addr[AP_BIT] = (beat == acc.beatsMinus1);
            end
            REF_PALL: begin
                p.csLines_n = refCs;
                p.rowStrobe_n = 1'b0;
                p.writeEnable_n = 1'b0;
                p.addr = ADDR_AP;
            end
            REF_MASK, SLEEP_MASK: begin
                p.maskLines_n = LINES_LOW;
            end
            REF_CBR: begin
                p.maskLines_n = LINES_LOW;
                p.csLines_n = refCs;
                p.rowStrobe_n = 1'b0;
                p.colStrobe_n = 1'b0;
            end
            REF_HOLD: begin
                p.maskLines_n = LINES_LOW;
                p.csLines_n = refCs;
            end
            IDLE, PWR_EXIT, RECOVER: begin
                p.clockEnable = CKE_HIGH;
            end
        endcase
        pinsFor = p;
    endfunction

    // System clock side: capture request, toggle across, await ack
    always_comb begin
        s_d = s_q;
        s_d.reqDone = 1'b0;
        s_d.ackMeta = m_q.ackTog;
        s_d.ackSync = s_q.ackMeta;
        s_d.srMeta = m_q.selfRefresh;
        s_d.srSync = s_q.srMeta;
        if (s_q.ackSync != s_q.ackSeen) begin
            s_d.ackSeen = s_q.ackSync;
            s_d.reqReady = 1'b1;
            s_d.reqDone = 1'b1;
        end else if (reqValid && s_q.reqReady) begin
            s_d.hold = reqAccess;
            s_d.reqTog = ~s_q.reqTog;
            s_d.reqReady = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= SYS_RESET;
            s_q.reqReady <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reqReady = s_q.reqReady;
    assign reqDone = s_q.reqDone;
    assign selfRefreshActive = s_q.srSync;

    // Memory clock side
    always_comb begin
        ctrl_type c;
        logic     lowPowerReq;
        logic     autoPd;
        logic     wakeReq;
        logic     bankOn;
        logic     clkStopped;
        c = m_q.ctrlSync;
        lowPowerReq = !c.clockEnablePinHold || !c.memClock1Run
                      || !c.memClock2Run;
        autoPd = c.ckeAutoPowerdownEn || c.clkAutoPowerdownEn;
        wakeReq = c.enterSleep || m_q.refreshDue || m_q.mrsPending
                  || m_q.accessPending;
        bankOn = s_q.hold.bank < BANKS
                 && c.dramBankEnables[s_q.hold.bank];
        clkStopped = 1'b0;
        m_d = m_q;
        m_d.rstMeta = rst_n;
        m_d.rstSync = m_q.rstMeta;
        m_d.ctrlMeta = ctrl;
        m_d.ctrlSync = m_q.ctrlMeta;
        m_d.reqMeta = s_q.reqTog;
        m_d.reqSync = m_q.reqMeta;

        if (m_q.reqSync != m_q.reqSeen) begin
            m_d.reqSeen = m_q.reqSync;
            m_d.accessPending = 1'b1;
        end
        if (m_q.timer != '0) begin
            m_d.timer = m_q.timer - 4'h1;
        end

        unique case (m_q.fsm)
            SELF_REF: begin
                if (m_q.accessPending) begin
                    m_d.accessPending = 1'b0;
                    m_d.ackTog = ~m_q.ackTog;
                end
                if (!c.enterSleep && !c.setSelfRefresh
                    && c.clockEnablePinHold) begin
                    m_d.fsm = PWR_EXIT;
                end
            end
            IDLE: begin
                if (c.enterSleep || c.setSelfRefresh) begin
                    m_d.fsm = SLEEP_MASK;
                    m_d.timer = MASK_LEAD_CYCLES - 4'h1;
                end else if (lowPowerReq) begin
                    m_d.fsm = LOW_POWER;
                end else if (m_q.refreshDue) begin
                    m_d.refreshDue = 1'b0;
                    m_d.disabledRefresh = 1'b0;
                    m_d.fsm = m_q.firstRefresh ? REF_PALL : REF_MASK;
                    m_d.timer = MASK_LEAD_CYCLES - 4'h1;
                end else if (m_q.mrsPending) begin
                    m_d.mrsPending = 1'b0;
                    m_d.fsm = MRS;
                end else if (m_q.accessPending) begin
                    if (bankOn) begin
                        m_d.fsm = ACT;
                    end else if (s_q.hold.beatsMinus1 == '0) begin
                        m_d.disabledRefresh = 1'b1;
                        m_d.fsm = m_q.firstRefresh ? REF_PALL : REF_MASK;
                        m_d.timer = MASK_LEAD_CYCLES - 4'h1;
                    end else begin
                        m_d.accessPending = 1'b0;
                        m_d.ackTog = ~m_q.ackTog;
                    end
                end else if (autoPd) begin
                    m_d.fsm = PWR_DOWN;
                end
            end
            LOW_POWER: begin
                if (!lowPowerReq) begin
                    m_d.fsm = PWR_EXIT;
                end
            end
            PWR_DOWN: begin
                if (wakeReq || !autoPd) begin
                    m_d.fsm = PWR_EXIT;
                end
            end
            PWR_EXIT, MRS: begin
                m_d.fsm = IDLE;
            end
            ACT: begin
                m_d.fsm = RW;
                m_d.beat = '0;
            end
            RW: begin
                if (m_q.beat == s_q.hold.beatsMinus1) begin
                    m_d.fsm = RECOVER;
                    m_d.timer = c.rowPrechargeTime;
                    m_d.accessPending = 1'b0;
                    m_d.ackTog = ~m_q.ackTog;
                end else begin
                    m_d.beat = m_q.beat + 3'h1;
                end
            end
            REF_PALL: begin
                m_d.firstRefresh = 1'b0;
                m_d.fsm = REF_MASK;
                m_d.timer = MASK_LEAD_CYCLES - 4'h1;
            end
            REF_MASK: begin
                if (m_q.timer == '0) begin
                    m_d.fsm = REF_CBR;
                end
            end
            REF_CBR: begin
                m_d.fsm = REF_HOLD;
                m_d.timer = c.refreshActiveTime;
            end
            REF_HOLD: begin
                if (m_q.timer == '0) begin
                    m_d.fsm = RECOVER;
                    m_d.timer = c.rowPrechargeTime;
                    if (m_q.disabledRefresh) begin
                        m_d.disabledRefresh = 1'b0;
                        m_d.accessPending = 1'b0;
                        m_d.ackTog = ~m_q.ackTog;
                    end
                end
            end
            RECOVER: begin
                if (m_q.timer == '0) begin
                    m_d.fsm = IDLE;
                end
            end
            SLEEP_MASK: begin
                if (m_q.timer == '0) begin
                    m_d.fsm = SLEEP_ENTER;
                end
            end
            SLEEP_ENTER: begin
                m_d.fsm = SELF_REF;
            end
            // Unused code falls back to the safe self-refresh state
            default: begin
                m_d.fsm = SELF_REF;
            end
        endcase

        // Any newly set enable schedules a mode register set; placed
        // after the state logic so a new enable beats the MRS clear
        if ((c.dramBankEnables & ~m_q.prevEnables) != LINES_LOW) begin
            m_d.mrsPending = 1'b1;
        end
        m_d.prevEnables = c.dramBankEnables;

        // Counter runs in every state so refresh survives core idle
        if (c.dramBankEnables != LINES_LOW
            && c.refreshIntervalField != '0) begin
            if (m_q.refCnt == {c.refreshIntervalField, 5'h00}) begin
                m_d.refCnt = REF_CNT_RESET;
                m_d.refreshDue = 1'b1;
            end else begin
                m_d.refCnt = m_q.refCnt + 17'h0_0001;
            end
        end

        m_d.selfRefresh = (m_d.fsm == SELF_REF);
        m_d.pins = pinsFor(m_d.fsm, s_q.hold, m_d.beat, c,
                           m_d.disabledRefresh);
        clkStopped = m_d.fsm == SELF_REF || m_d.fsm == SLEEP_ENTER;
        if (clkStopped) begin
            m_d.mclk = {2'h3, ~c.clkAutoPowerdownEn};
        end else if (m_d.fsm == PWR_DOWN && c.clkAutoPowerdownEn) begin
            m_d.mclk[0] = 1'b0;
        end else begin
            m_d.mclk[0] = ~m_q.mclk[0];
            m_d.mclk[1] = c.memClock1Run ? ~m_q.mclk[1] : m_q.mclk[1];
            m_d.mclk[2] = c.memClock2Run ? ~m_q.mclk[2] : m_q.mclk[2];
        end

        // Synchronised reset; keeps the synchroniser itself running
        if (!m_q.rstSync) begin
            m_d.fsm = SELF_REF;
            m_d.pins = PINS_SELF_REFRESH;
            m_d.mclk = MCLK_RESET;
            m_d.refCnt = REF_CNT_RESET;
            m_d.refreshDue = 1'b0;
            m_d.firstRefresh = 1'b1;
            m_d.prevEnables = '0;
            m_d.mrsPending = 1'b0;
            m_d.accessPending = 1'b0;
            m_d.reqSeen = m_q.reqSync;
            m_d.ackTog = 1'b0;
            m_d.timer = '0;
            m_d.beat = '0;
            m_d.disabledRefresh = 1'b0;
            m_d.selfRefresh = 1'b1;
        end
    end

    // Reset reaches this domain through rstSync; no reset branch here
    always_ff @(posedge memClk) begin
        m_q <= m_d;
    end

    assign memPins = m_q.pins;
    assign syncMemoryClockOut = m_q.mclk;

endmodule

/* File: dv/sdram_refresh_assertions.sv */
// Checker for the memory-side pins of the refresh sequencer.
// Assumes ctrl stays steady while a watched sequence runs.
module sdram_refresh_assertions (
    input wire logic                        rst_n,
    input wire logic                        memClk,
    input wire sdram_refresh_pkg::ctrl_type ctrl,
    input wire sdram_refresh_pkg::pins_type memPins,
    input wire logic [2:0]                  syncMemoryClockOut
);
    import sdram_refresh_pkg::*;
    pins_type   p;
    logic       busy, csLow, isAct, isRw, isCbr, isPall, isMrs;
    logic       isEnter, isSelfRef, cbrSeen_q, pallSeen_q;
    logic [7:0] lowCnt_q;
    assign p = memPins;
    assign busy = p.csLines_n != LINES_HIGH;
    // Clock enable and write strobe keep sleep and writes out of the span
    assign csLow = busy && p.maskLines_n == LINES_LOW
                   && p.clockEnable == CKE_HIGH && p.writeEnable_n;
    assign isAct = busy && !p.rowStrobe_n && p.colStrobe_n && p.writeEnable_n;
    assign isRw = busy && p.rowStrobe_n && !p.colStrobe_n;
    assign isCbr = csLow && !p.rowStrobe_n && !p.colStrobe_n
                   && p.writeEnable_n;
    assign isPall = busy && !p.rowStrobe_n && p.colStrobe_n
                    && !p.writeEnable_n;
    assign isMrs = busy && !p.rowStrobe_n && !p.colStrobe_n
                   && !p.writeEnable_n;
    assign isEnter = p.csLines_n == LINES_LOW && p.maskLines_n == LINES_LOW
                     && !p.rowStrobe_n && !p.colStrobe_n
                     && p.clockEnable == CKE_LOW;
    assign isSelfRef = p.csLines_n == LINES_LOW && p.rowStrobe_n
                       && p.maskLines_n == LINES_LOW && p.colStrobe_n
                       && p.clockEnable == CKE_LOW;
    always_ff @(posedge memClk) begin
        if (!rst_n) begin
            lowCnt_q   <= 8'h00;
            cbrSeen_q  <= 1'b0;
            pallSeen_q <= 1'b0;
        end else begin
            lowCnt_q   <= csLow ? lowCnt_q + 8'h01 : 8'h00;
            cbrSeen_q  <= cbrSeen_q | isCbr;
            pallSeen_q <= pallSeen_q | isPall;
        end
    end
    default clocking cb @(posedge memClk); endclocking
    default disable iff (!rst_n);
    sequence s_sr_hold;
        isSelfRef ##1 isSelfRef;
    endsequence
    property p_act_rw;
        isAct |=> isRw;
    endproperty
    a_act_rw: assert property (p_act_rw)
        else $error("activate not followed by a beat");
    property p_beat_plain;
        isRw && !p.addr[AP_BIT] |=> isRw;
    endproperty
    a_beat_plain: assert property (p_beat_plain)
        else $error("plain beat was the last one");
    property p_beat_last;
        isRw && p.addr[AP_BIT] |=> p.csLines_n == LINES_HIGH;
    endproperty
    a_beat_last: assert property (p_beat_last)
        else $error("beat issued after auto-precharge");
    property p_mask_lead;
        busy && !$past(busy) && p.maskLines_n == LINES_LOW
        |-> $past(p.maskLines_n) == LINES_LOW
            && $past(p.maskLines_n, 2) == LINES_LOW;
    endproperty
    a_mask_lead: assert property (p_mask_lead)
        else $error("selects fell without two mask cycles");
    property p_cbr_nop;
        isCbr |=> p.rowStrobe_n && p.colStrobe_n;
    endproperty
    a_cbr_nop: assert property (p_cbr_nop)
        else $error("strobes low after refresh command");
    property p_cs_span;
        $past(csLow) && !busy
        |-> lowCnt_q == 8'(ctrl.refreshActiveTime) + 8'h02
            && p.maskLines_n == LINES_HIGH;
    endproperty
    a_cs_span: assert property (p_cs_span)
        else $error("refresh select span wrong");
    property p_pall_first;
        isCbr && !cbrSeen_q |-> pallSeen_q;
    endproperty
    a_pall_first: assert property (p_pall_first)
        else $error("first refresh without precharge all");
    property p_mrs_mode;
        isMrs |-> p.addr == (ADDR_W'(ctrl.casLatencyField) << MRS_CL_LSB)
                  && p.csLines_n == ~ctrl.dramBankEnables;
    endproperty
    a_mrs_mode: assert property (p_mrs_mode)
        else $error("mode register value wrong");
    property p_enter_hold;
        isEnter |=> isSelfRef;
    endproperty
    a_enter_hold: assert property (p_enter_hold)
        else $error("self-refresh pins not held");
    property p_sleep_clk;
        s_sr_hold |-> syncMemoryClockOut[2:1] == 2'b11
            && syncMemoryClockOut[0] == !ctrl.clkAutoPowerdownEn;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk)
        else $error("memory clocks not parked in sleep");
endmodule

bind sdram_dram_refresh_sequencer sdram_refresh_assertions chk (
    .rst_n(rst_n), .memClk(memClk), .ctrl(ctrl), .memPins(memPins),
    .syncMemoryClockOut(syncMemoryClockOut));

/* File: dv/sdram_device_model.sv */
// Far-side SDRAM model: decodes and counts commands on the pins.
// Assumes pins move only on memClk rising edges; returns no data.
module sdram_device_model (
    input  wire logic                        memClk,
    input  wire sdram_refresh_pkg::pins_type memPins,
    output int                               actCnt,
    output int                               rwCnt,
    output int                               cbrCnt,
    output int                               pallCnt,
    output int                               mrsCnt,
    output int                               busyCnt
);
    import sdram_refresh_pkg::*;
    logic sel, ras, cas, we;
    assign sel = memPins.csLines_n != LINES_HIGH;
    assign ras = memPins.rowStrobe_n;
    assign cas = memPins.colStrobe_n;
    assign we = memPins.writeEnable_n;
    initial {actCnt, rwCnt, cbrCnt, pallCnt, mrsCnt, busyCnt} = '0;
    // Decoded commands only count with clock enable high, as a device sees them; busyCnt counts every selected cycle
    always @(posedge memClk) begin
        if (sel) busyCnt++;
        if (sel && memPins.clockEnable == CKE_HIGH) begin
            if (!ras && cas && we) actCnt++;
            if (ras && !cas) rwCnt++;
            if (!ras && !cas && we) cbrCnt++;
            if (!ras && cas && !we) pallCnt++;
            if (!ras && !cas && !we) mrsCnt++;
        end
    end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the refresh sequencer.
// Assumes the far-side model only observes the memory pins.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sdram_refresh_pkg::*;
    logic       clk, rst_n, memClk, reqValid, reqReady, reqDone, srActive;
    ctrl_type   ctrl;
    access_type reqAccess;
    pins_type   memPins;
    logic [2:0] memClkOut;
    int         actCnt, rwCnt, cbrCnt, pallCnt, mrsCnt, busyCnt;
    int         errors, total_checks, seen;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        memClk = 1'b0;
        #1.3;
        forever #7.5 memClk = ~memClk;
    end

    sdram_dram_refresh_sequencer uut (
        .clk(clk), .rst_n(rst_n), .memClk(memClk), .ctrl(ctrl),
        .reqValid(reqValid), .reqAccess(reqAccess), .reqReady(reqReady),
        .reqDone(reqDone), .selfRefreshActive(srActive),
        .memPins(memPins), .syncMemoryClockOut(memClkOut));
    sdram_device_model model (
        .memClk(memClk), .memPins(memPins), .actCnt(actCnt),
        .rwCnt(rwCnt), .cbrCnt(cbrCnt), .pallCnt(pallCnt),
        .mrsCnt(mrsCnt), .busyCnt(busyCnt));

    task automatic summarize();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic memWait(input int n);
        repeat (n) @(posedge memClk);
        @(posedge clk);
    endtask
    // Holds the request until accepted, then waits for the done pulse
    task automatic access(input logic w, input logic [1:0] b,
                          input logic [2:0] n);
        int i;
        i = 0;
        reqValid  <= 1'b1;
        reqAccess <= '{write: w, bank: b, beatsMinus1: n,
                       row: 15'h0123, col: 15'h0040};
        do begin
            @(posedge clk);
            i++;
        end while (reqReady !== 1'b1 && i < 4000);
        reqValid <= 1'b0;
        do begin
            @(posedge clk);
            i++;
        end while (reqDone !== 1'b1 && i < 8000);
        check(reqDone === 1'b1, "access not completed");
    endtask

    initial begin
        #50000;
        errors++;
        summarize();
    end

    initial begin
        errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqAccess = '0;
        ctrl = '0;
        ctrl.refreshActiveTime = 4'h2;
        ctrl.rowPrechargeTime = 4'h1;
        ctrl.casLatencyField = 2'h2;
        ctrl.memClock1Run = 1'b1;
        ctrl.memClock2Run = 1'b1;
        ctrl.clkAutoPowerdownEn = 1'b1;
        // Counted in memory clocks so the synchroniser sees the reset
        repeat (12) @(posedge memClk);
        @(posedge clk);
        rst_n <= 1'b1;
        memWait(20);
        check(srActive === 1'b1, "not in self-refresh");
        access(1'b1, 2'h0, 3'h0);
        check(actCnt == 0, "activity in self-refresh");
        ctrl.clockEnablePinHold <= 1'b1;
        memWait(20);
        check(srActive === 1'b0, "self-refresh not left");
        ctrl.dramBankEnables <= 4'h1;
        memWait(20);
        check(mrsCnt == 1, "mode set missing");
        access(1'b1, 2'h0, 3'h0);
        access(1'b0, 2'h0, 3'h3);
        memWait(10);
        check(actCnt == 2 && rwCnt == 5, "beat count");
        access(1'b0, 2'h2, 3'h0);
        access(1'b0, 2'h2, 3'h2);
        memWait(10);
        check(cbrCnt == 1 && pallCnt == 1, "disabled bank refresh");
        check(actCnt == 2, "disabled bank activated");
        ctrl.refreshIntervalField <= 12'h001;
        memWait(200);
        seen = cbrCnt - 1;
        check(seen >= 4 && seen <= 6, "refresh rate");
        access(1'b1, 2'h0, 3'h1);
        ctrl.clockEnablePinHold <= 1'b0;
        memWait(20);
        seen = busyCnt;
        memWait(150);
        check(busyCnt == seen, "commands in low power");
        seen = cbrCnt;
        ctrl.clockEnablePinHold <= 1'b1;
        memWait(40);
        check(cbrCnt > seen, "refresh not resumed");
        ctrl.enterSleep <= 1'b1;
        memWait(30);
        check(srActive === 1'b1, "sleep entry");
        seen = actCnt;
        access(1'b0, 2'h0, 3'h0);
        check(actCnt == seen, "access in sleep");
        ctrl.enterSleep <= 1'b0;
        memWait(30);
        check(srActive === 1'b0, "sleep exit");
        ctrl.setSelfRefresh <= 1'b1;
        memWait(60);
        check(srActive === 1'b1, "self-refresh bit entry");
        ctrl.setSelfRefresh <= 1'b0;
        memWait(30);
        check(srActive === 1'b0, "self-refresh bit exit");
        ctrl.refreshIntervalField <= 12'h000;
        ctrl.ckeAutoPowerdownEn <= 1'b1;
        memWait(30);
        check(memPins.clockEnable === CKE_LOW, "no power-down");
        ctrl.ckeAutoPowerdownEn <= 1'b0;
        ctrl.clkAutoPowerdownEn <= 1'b0;
        ctrl.memClock1Run <= 1'b0;
        memWait(10);
        seen = memClkOut[1];
        memWait(5);
        check(memClkOut[1] === seen[0], "clock 1 not stopped");
        summarize();
    end
endmodule
